// [rtl/ocpu_top.sv]
// Overcurrent pick-up stage: blocking, status, timing and ratio
`timescale 1ns/1ns
`default_nettype none
`include "ocpu_defines.svh"
module ocpu_top #(
  parameter int CYCLE_CLKS = `OCPU_CYCLE_CLKS
) (
  input  wire logic                             mclk,
  input  wire logic                             rstn,
  input  wire logic [2:0][`OCPU_MAG_W-1:0]      mag_rms,
  input  wire logic [2:0][`OCPU_MAG_W-1:0]      mag_true_rms_value,
  input  wire logic [2:0][`OCPU_MAG_W-1:0]      mag_pp,
  input  wire logic [1:0]                       meas_sel,
  input  wire logic                             blk_in,
  input  wire logic                             inrush_en,
  input  wire logic [15:0]                      h2_ratio,
  input  wire logic [15:0]                      h2_limit,
  input  wire logic                             group_sel,
  input  wire logic                             iset_wr,
  input  wire logic                             iset_wgrp,
  input  wire logic [`OCPU_MAG_W-1:0]           iset_wdata,
  input  wire logic                             inv_mode,
  input  wire logic [`OCPU_TIME_W-1:0]          dt_delay,
  input  wire logic [15:0]                      inv_k,
  input  wire logic [2:0]                       ln_mode,
  input  wire logic                             force_en,
  input  wire logic [3:0]                       force_cond,
  input  wire logic [2:0]                       force_ph_start,
  input  wire logic [2:0]                       force_ph_trip,
  output logic [3:0]                            cond,
  output logic [2:0]                            ph_start,
  output logic [2:0]                            ph_trip,
  output logic                                  start,
  output logic                                  trip,
  output logic                                  blocked,
  output logic [`OCPU_TIME_W-1:0]               exp_time,
  output logic signed [`OCPU_TIME_W:0]          rem_time,
  output logic [`OCPU_RATIO_W-1:0]              ratio,
  output logic [2:0]                            ln_beh,
  output logic                                  iset_rej
);
  localparam int TW = `OCPU_TIME_W;
  localparam int DW = `OCPU_DIV_W;
  localparam int MW = `OCPU_MAG_W;
  localparam int KW = $clog2(CYCLE_CLKS);

  function automatic logic [MW-1:0] max3(input logic [2:0][MW-1:0] v);
    logic [MW-1:0] m;
    m = (v[0] > v[1]) ? v[0] : v[1];
    return (m > v[2]) ? m : v[2];
  endfunction : max3

  function automatic ocpu_pkg::ocpu_cond_e cond_of(input logic s, input logic t,
                                                   input logic b);
    ocpu_pkg::ocpu_cond_e c;
    c = ocpu_pkg::C_NORMAL;
    if (b) c = ocpu_pkg::C_BLOCKED;
    else if (t) c = ocpu_pkg::C_TRIP;
    else if (s) c = ocpu_pkg::C_START;
    return c;
  endfunction : cond_of

  ////////////////////////////////////////////////////////////////////////////
  // Processing cycle tick and blocking input synchroniser

  logic [KW-1:0] cyc_q;
  logic          tick;
  logic          blk_s1_q;
  logic          blk_s2_q;
  assign tick = (cyc_q == KW'(CYCLE_CLKS - 1));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cyc_q <= '0;
    end else if (tick) begin
      cyc_q <= '0; // [R23]
    end else begin
      cyc_q <= cyc_q + KW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      blk_s1_q <= 1'b0;
      blk_s2_q <= 1'b0;
    end else begin
      blk_s1_q <= blk_in;
      blk_s2_q <= blk_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold banks per setting group

  logic [1:0][MW-1:0] iset_q;
  logic               grp_q;
  logic               iset_rej_q;
  logic               iset_ok;
  assign iset_ok = (iset_wdata >= `OCPU_ISET_MIN) && (iset_wdata <= `OCPU_ISET_MAX);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      iset_q     <= {`OCPU_ISET_DEF, `OCPU_ISET_DEF}; // [R5]
      iset_rej_q <= 1'b0;
    end else if (iset_wr) begin
      if (iset_ok) begin
        iset_q[iset_wgrp] <= iset_wdata;
      end
      iset_rej_q <= !iset_ok; // [R26]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle-start capture of measurements, group and blocking

  logic [2:0][MW-1:0] mag_q;
  logic               blk_q;
  logic               inrush;
  logic               ln_blk;
  logic               ln_off;
  assign inrush = inrush_en && (h2_ratio > h2_limit); // [R17] [R18] [R25]
  assign ln_blk = (ln_mode == ocpu_pkg::LN_BLOCKED) || (ln_mode == ocpu_pkg::LN_TESTBLK);
  assign ln_off = (ln_mode == ocpu_pkg::LN_OFF);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mag_q <= '0;
      blk_q <= 1'b0;
      grp_q <= 1'b0;
    end else if (tick) begin
      case (meas_sel)
        ocpu_pkg::MS_TRUE_RMS_VALUE: mag_q <= mag_true_rms_value; // [R22]
        ocpu_pkg::MS_PP:   mag_q <= mag_pp;
        default:           mag_q <= mag_rms;
      endcase
      blk_q <= blk_s2_q || inrush || ln_blk; // [R13]
      grp_q <= group_sel; // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase comparators and divider

  ocpu_pkg::ocpu_seq_e st_q;
  ocpu_meas_if         mif ();
  logic                div_go_q;
  logic [DW-1:0]       div_num_q;
  logic [DW-1:0]       div_den_q;
  logic                div_done;
  logic [DW-1:0]       div_quo;

  assign mif.mag  = mag_q;
  assign mif.iset = iset_q[grp_q];
  assign mif.eval = (st_q == ocpu_pkg::S_EVAL);

  ocpu_phase_cmp u_cmp (
    .mclk (mclk),
    .rstn (rstn),
    .mif  (mif)
  );

  ocpu_div #(.W(DW)) u_div (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (div_go_q),
    .num   (div_num_q),
    .den   (div_den_q),
    .done  (div_done),
    .quo   (div_quo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q <= ocpu_pkg::S_IDLE;
    end else begin
      case (st_q)
        ocpu_pkg::S_IDLE:   if (tick) st_q <= ocpu_pkg::S_EVAL;
        ocpu_pkg::S_EVAL:   st_q <= ocpu_pkg::S_DECIDE;
        ocpu_pkg::S_DECIDE: st_q <= ocpu_pkg::S_RATIO;
        ocpu_pkg::S_RATIO:  if (div_done) st_q <= ocpu_pkg::S_TIME;
        ocpu_pkg::S_TIME:   if (div_done) st_q <= ocpu_pkg::S_IDLE;
        default:            st_q <= ocpu_pkg::S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ratio and expected operating time

  logic [`OCPU_RATIO_W-1:0] ratio_q;
  logic [TW-1:0]            exp_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_go_q  <= 1'b0;
      div_num_q <= '0;
      div_den_q <= '0;
    end else begin
      div_go_q <= 1'b0;
      if (st_q == ocpu_pkg::S_DECIDE) begin
        div_go_q  <= 1'b1;
        div_num_q <= DW'(max3(mag_q)) * `OCPU_RATIO_ONE;
        div_den_q <= DW'(iset_q[grp_q]);
      end else if ((st_q == ocpu_pkg::S_RATIO) && div_done) begin
        div_go_q  <= 1'b1;
        div_num_q <= DW'(inv_k) * `OCPU_RATIO_ONE;
        div_den_q <= (div_quo > `OCPU_RATIO_ONE) ? div_quo - `OCPU_RATIO_ONE : '0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ratio_q <= '0;
      exp_q   <= '0;
    end else if (div_done) begin
      if (st_q == ocpu_pkg::S_RATIO) begin
        ratio_q <= (div_quo > DW'(`OCPU_RATIO_MAX)) ? `OCPU_RATIO_MAX
                                                    : div_quo[`OCPU_RATIO_W-1:0]; // [R12]
      end else if (st_q == ocpu_pkg::S_TIME) begin
        if (!inv_mode) begin
          exp_q <= dt_delay; // [R20]
        end else if (div_quo > DW'(`OCPU_TIME_MAX)) begin
          exp_q <= `OCPU_TIME_MAX;
        end else begin
          exp_q <= div_quo[TW-1:0]; // [R9] [R10]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start, trip and blocked decision

  logic          start_q;
  logic          trip_q;
  logic          blkd_q;
  logic [TW-1:0] cnt_q;
  logic [TW-1:0] cnt_d;
  logic [2:0]    phs_q;
  logic [2:0]    pht_q;
  logic          any_pick;
  logic [TW-1:0] exp_lim;
  assign any_pick = |mif.pick;
  assign cnt_d = cnt_q + TW'(1);
  // Definite delay taken live so a fresh setting or reset never trips early
  assign exp_lim = inv_mode ? exp_q : dt_delay; // [R20]

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      start_q <= 1'b0;
      trip_q  <= 1'b0;
      blkd_q  <= 1'b0;
      cnt_q   <= '0;
      phs_q   <= '0;
      pht_q   <= '0;
    end else if (st_q == ocpu_pkg::S_DECIDE) begin
      if (ln_off || !any_pick) begin
        start_q <= 1'b0;
        trip_q  <= 1'b0;
        blkd_q  <= 1'b0;
        cnt_q   <= '0;
        phs_q   <= '0;
        pht_q   <= '0;
      end else if (blk_q) begin
        start_q <= 1'b0; // [R15] [R16]
        trip_q  <= 1'b0;
        blkd_q  <= 1'b1;
        cnt_q   <= '0;
        phs_q   <= '0;
        pht_q   <= '0;
      end else begin
        start_q <= 1'b1; // [R14]
        blkd_q  <= 1'b0;
        cnt_q   <= (cnt_q == `OCPU_TIME_MAX) ? cnt_q : cnt_d;
        trip_q  <= (cnt_d >= exp_lim); // [R20]
        phs_q   <= mif.pick; // [R8]
        pht_q   <= (cnt_d >= exp_lim) ? mif.pick : 3'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers with forcing

  ocpu_pkg::ocpu_cond_e     cond_q;
  logic [2:0]               ph_start_q;
  logic [2:0]               ph_trip_q;
  logic                     start_o_q;
  logic                     trip_o_q;
  logic                     blkd_o_q;
  logic [TW-1:0]            exp_o_q;
  logic signed [TW:0]       rem_q;
  logic [`OCPU_RATIO_W-1:0] ratio_o_q;
  logic [2:0]               ln_q;
  logic                     rej_o_q;
  logic                     f_ok;
  ocpu_pkg::ocpu_cond_e     f_cond;
  assign f_ok   = $onehot(force_cond);
  assign f_cond = f_ok ? ocpu_pkg::ocpu_cond_e'(force_cond) : ocpu_pkg::C_NORMAL;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cond_q     <= ocpu_pkg::C_NORMAL;
      ph_start_q <= '0;
      ph_trip_q  <= '0;
      start_o_q  <= 1'b0;
      trip_o_q   <= 1'b0;
      blkd_o_q   <= 1'b0;
    end else if (force_en) begin
      cond_q     <= f_cond; // [R24]
      ph_start_q <= force_ph_start;
      ph_trip_q  <= force_ph_trip;
      start_o_q  <= (f_cond == ocpu_pkg::C_START);
      trip_o_q   <= (f_cond == ocpu_pkg::C_TRIP);
      blkd_o_q   <= (f_cond == ocpu_pkg::C_BLOCKED);
    end else begin
      cond_q     <= cond_of(start_q, trip_q, blkd_q); // [R7]
      ph_start_q <= phs_q;
      ph_trip_q  <= pht_q;
      start_o_q  <= start_q;
      trip_o_q   <= trip_q && (ln_mode != ocpu_pkg::LN_TESTBLK);
      blkd_o_q   <= blkd_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      exp_o_q   <= '0;
      rem_q     <= '0;
      ratio_o_q <= '0;
      ln_q      <= ocpu_pkg::LN_ON;
      rej_o_q   <= 1'b0;
    end else begin
      exp_o_q   <= exp_q;
      rem_q     <= start_q ? $signed({1'b0, exp_q}) - $signed({1'b0, cnt_q}) : '0; // [R11]
      ratio_o_q <= ratio_q;
      ln_q      <= ln_mode; // [R21]
      rej_o_q   <= iset_rej_q;
    end
  end

  assign cond     = cond_q;
  assign ph_start = ph_start_q;
  assign ph_trip  = ph_trip_q;
  assign start    = start_o_q;
  assign trip     = trip_o_q;
  assign blocked  = blkd_o_q;
  assign exp_time = exp_o_q;
  assign rem_time = rem_q;
  assign ratio    = ratio_o_q;
  assign ln_beh   = ln_q;
  assign iset_rej = rej_o_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  logic in_dec;
  assign in_dec = (st_q == ocpu_pkg::S_DECIDE) && !ln_off && any_pick;

  property p_start;
    in_dec && !blk_q |=> start_q && !blkd_q ##2 start && !blocked;
  endproperty
  a_start: assert property (p_start) else $error("Start not raised"); // [R14]

  property p_block;
    in_dec && blk_q |=> blkd_q && !start_q && (cnt_q == '0) ##2 blocked && !start;
  endproperty
  a_block: assert property (p_block) else $error("Blocked not raised"); // [R15]

  property p_blk_sample;
    !tick |=> $stable(blk_q);
  endproperty
  a_blk_sample: assert property (p_blk_sample) else $error("Block sampled mid-cycle"); // [R13]

  property p_inrush;
    tick && inrush_en && (h2_ratio > h2_limit) |=> blk_q;
  endproperty
  a_inrush: assert property (p_inrush) else $error("Inrush block missed"); // [R25]

  property p_cond;
    $onehot(cond) && (blocked == (cond == ocpu_pkg::C_BLOCKED));
  endproperty
  a_cond: assert property (p_cond) else $error("Condition not one-hot"); // [R7]

  property p_reject;
    iset_wr && !iset_ok |=> iset_rej_q && $stable(iset_q) ##1 iset_rej;
  endproperty
  a_reject: assert property (p_reject) else $error("Bad threshold accepted"); // [R26]

  property p_trip;
    in_dec && !blk_q && (cnt_d >= exp_lim) |=> trip_q && (pht_q == phs_q);
  endproperty
  a_trip: assert property (p_trip) else $error("Trip not raised at expiry"); // [R20]

  property p_ratio;
    (st_q == ocpu_pkg::S_RATIO) && div_done |=> (ratio_q <= `OCPU_RATIO_MAX) ##2
      (ratio == $past(ratio_q, 1));
  endproperty
  a_ratio: assert property (p_ratio) else $error("Ratio out of range"); // [R12]

  property p_force;
    force_en && $onehot(force_cond) |=> cond == $past(force_cond);
  endproperty
  a_force: assert property (p_force) else $error("Forced status not shown"); // [R24]

  c_trip: cover property (trip);
  c_blocked: cover property (start ##[1:50] blocked);
  c_force: cover property (force_en && cond == ocpu_pkg::C_TRIP);
  c_reject: cover property (iset_rej);
endmodule : ocpu_top
`default_nettype wire

// [rtl/ocpu_defines.svh]
// Constants of the overcurrent pick-up stage
// Notes on behaviour
// R1: Compare each phase magnitude against threshold separately
// R2: Pick up when any phase exceeds threshold
// R3: Release only below fixed 97 percent level
// R4: One threshold shared by all three phases
// R5: Threshold in 0.01 In steps, default 1.20
// R6: Setting group switch while running, no stop
// R7: Condition is normal, start, trip or blocked
// R8: Per-phase start and trip for any phases
// R9: Expected time, 5 ms steps, from highest phase
// R10: Expected time recalculated when current changes
// R11: Remaining time to trip shown while counting
// R12: Highest phase to threshold ratio, 0.01 steps
// R13: Blocking sampled at start of each cycle
// R14: Pick-up without blocking raises start, starts timing
// R15: Pick-up under blocking raises blocked, nothing else
// R16: Blocking during start clears start like drop-off
// R17: Optional second-harmonic inrush block, default off
// R18: Harmonic limit in 0.01 percent steps
// R19: External block must lead delay by 5 ms
// R20: Definite-time and inverse-time delays both supported
// R21: Report node behaviour on/blocked/test/test-blocked/off
// R22: Select fundamental, true RMS or peak-to-peak
// R23: Processing cycle of 5 ms
// R24: Forcing overrides status, default normal
// R25: Harmonic ratio above limit is internal block
// R26: Threshold limited 0.10 to 50.00, else rejected
`ifndef OCPU_DEFINES_SVH
`define OCPU_DEFINES_SVH
`define OCPU_MAG_W       16
`define OCPU_TIME_W      19
`define OCPU_RATIO_W     17
`define OCPU_DIV_W       32
`define OCPU_ISET_DEF    16'h0078
`define OCPU_ISET_MIN    16'h000a
`define OCPU_ISET_MAX    16'h1388
`define OCPU_PCT_FULL    24'h000064
`define OCPU_PCT_RESET   24'h000061
`define OCPU_RATIO_ONE   32'h00000064
`define OCPU_RATIO_MAX   17'h1e848
`define OCPU_TIME_MAX    19'h57e40
`define OCPU_CLK_KHZ     250000
`define OCPU_CYCLE_MS    5
`define OCPU_CYCLE_CLKS  (`OCPU_CYCLE_MS * `OCPU_CLK_KHZ)
`define OCPU_BLK_LEAD_MS 5
`endif

// [rtl/ocpu_pkg.sv]
// Types of the overcurrent pick-up stage
package ocpu_pkg;
  typedef enum logic [3:0] {
    C_NORMAL  = 4'h1,
    C_START   = 4'h2,
    C_TRIP    = 4'h4,
    C_BLOCKED = 4'h8
  } ocpu_cond_e;
  typedef enum logic [2:0] {
    LN_ON      = 3'h0,
    LN_BLOCKED = 3'h1,
    LN_TEST    = 3'h2,
    LN_TESTBLK = 3'h3,
    LN_OFF     = 3'h4
  } ocpu_ln_e;
  typedef enum logic [1:0] {
    MS_RMS  = 2'h0,
    MS_TRUE_RMS_VALUE = 2'h1,
    MS_PP   = 2'h2
  } ocpu_msel_e;
  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,
    S_EVAL   = 5'h02,
    S_DECIDE = 5'h04,
    S_RATIO  = 5'h08,
    S_TIME   = 5'h10
  } ocpu_seq_e;
endpackage : ocpu_pkg

// [rtl/ocpu_meas_if.sv]
// Phase magnitudes, threshold and pick-up flags between stage modules
`timescale 1ns/1ns
`default_nettype none
`include "ocpu_defines.svh"
interface ocpu_meas_if;
  logic [2:0][`OCPU_MAG_W-1:0] mag;
  logic [`OCPU_MAG_W-1:0]      iset;
  logic                        eval;
  logic [2:0]                  pick;
  modport src (output mag, output iset, output eval, input pick);
  modport cmp (input mag, input iset, input eval, output pick);
endinterface : ocpu_meas_if
`default_nettype wire

// [rtl/ocpu_phase_cmp.sv]
// Per-phase pick-up comparators with fixed release hysteresis
`timescale 1ns/1ns
`default_nettype none
`include "ocpu_defines.svh"
module ocpu_phase_cmp (
  input  wire logic mclk,
  input  wire logic rstn,
  ocpu_meas_if.cmp  mif
);
  logic [2:0] pick_q;
  logic [23:0] t_full;
  logic [23:0] t_rel;
  assign t_full = 24'(mif.iset) * `OCPU_PCT_FULL; // [R4]
  assign t_rel  = 24'(mif.iset) * `OCPU_PCT_RESET;
  assign mif.pick = pick_q;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ph
      logic [23:0] m100;
      assign m100 = 24'(mif.mag[i]) * `OCPU_PCT_FULL;
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          pick_q[i] <= 1'b0;
        end else if (mif.eval) begin
          if (pick_q[i]) begin
            pick_q[i] <= (m100 >= t_rel); // [R3]
          end else begin
            pick_q[i] <= (m100 > t_full); // [R1] [R2]
          end
        end
      end
      property p_pick;
        @(posedge mclk) disable iff (!rstn)
        mif.eval && (m100 > t_full) |=> pick_q[i];
      endproperty
      a_pick: assert property (p_pick) else $error("Phase did not pick up"); // [R2]
      property p_hold;
        @(posedge mclk) disable iff (!rstn)
        mif.eval && pick_q[i] && (m100 >= t_rel) |=> pick_q[i];
      endproperty
      a_hold: assert property (p_hold) else $error("Phase released above reset level"); // [R3]
    end
  endgenerate
endmodule : ocpu_phase_cmp
`default_nettype wire

// [rtl/ocpu_div.sv]
// Iterative unsigned divider, quotient and done from registers
`timescale 1ns/1ns
`default_nettype none
module ocpu_div #(
  parameter int W = 32
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  output logic              done,
  output logic [W-1:0]      quo
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0]  rem_q;
  logic [W-1:0]  quo_q;
  logic [W-1:0]  den_q;
  logic [CW-1:0] cnt_q;
  logic          done_q;
  logic [W:0]    r_sh;
  assign r_sh = {rem_q, quo_q[W-1]};
  assign done = done_q;
  assign quo  = quo_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rem_q  <= '0;
      quo_q  <= '0;
      den_q  <= '0;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (start) begin
      rem_q  <= '0;
      quo_q  <= num;
      den_q  <= den;
      cnt_q  <= CW'(W);
      done_q <= 1'b0;
    end else if (cnt_q != '0) begin
      if (r_sh >= {1'b0, den_q}) begin
        rem_q <= W'(r_sh - {1'b0, den_q});
        quo_q <= {quo_q[W-2:0], 1'b1};
      end else begin
        rem_q <= r_sh[W-1:0];
        quo_q <= {quo_q[W-2:0], 1'b0};
      end
      cnt_q  <= cnt_q - CW'(1);
      done_q <= (cnt_q == CW'(1));
    end else begin
      done_q <= 1'b0;
    end
  end
endmodule : ocpu_div
`default_nettype wire

// [tb/ocpu_front.sv]
// Model of the measurement front end and blocking matrix
`timescale 1ns/1ns
`default_nettype none
`include "ocpu_defines.svh"
module ocpu_front #(
  parameter int CYC = 200
) (
  input  wire logic                        mclk,
  output logic [2:0][`OCPU_MAG_W-1:0]      mag_rms,
  output logic [2:0][`OCPU_MAG_W-1:0]      mag_true_rms_value,
  output logic [2:0][`OCPU_MAG_W-1:0]      mag_pp,
  output logic                             blk_in
);
  logic [2:0][`OCPU_MAG_W-1:0] r_n, t_n, p_n;
  int                          cnt = 0;
  initial begin
    {mag_rms, mag_true_rms_value, mag_pp, r_n, t_n, p_n} = '0;
    blk_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Magnitudes refreshed once per time base
  always @(posedge mclk) begin
    cnt <= (cnt == CYC - 1) ? 0 : cnt + 1;
    if (cnt == CYC - 1) begin
      mag_rms  <= r_n;
      mag_true_rms_value <= t_n;
      mag_pp   <= p_n;
    end
  end
  task set_mag(input logic [2:0][15:0] r, t, p);
    r_n = r;
    t_n = t;
    p_n = p;
  endtask : set_mag
  // Caller raises the block well ahead of the delay
  task set_blk(input logic b);
    blk_in = b;
  endtask : set_blk
endmodule : ocpu_front
`default_nettype wire

// [tb/tb.sv]
// Testbench of the overcurrent pick-up stage
`timescale 1ns/1ns
`default_nettype none
`include "ocpu_defines.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %s: expected %0h seen %0h", n, e, a); end end
module tb;
  localparam int CYC = 200;
  logic mclk = 0, rstn = 0, inrush_en = 0, group_sel = 0, iset_wr = 0, iset_wgrp = 0;
  logic inv_mode = 0, force_en = 0, blk_in, start, trip, blocked, iset_rej;
  logic [2:0][15:0] mag_rms, mag_true_rms_value, mag_pp;
  logic [1:0]       meas_sel = '0;
  logic [15:0]      h2_ratio = '0, h2_limit = 16'h0064, iset_wdata = '0, inv_k = '0;
  logic [18:0]      dt_delay = 19'h003e8, exp_time;
  logic [2:0]       ln_mode = '0, force_ph_start = '0, force_ph_trip = '0;
  logic [2:0]       ph_start, ph_trip, ln_beh;
  logic [3:0]       force_cond = '0, cond;
  logic signed [19:0] rem_time;
  logic [16:0]      ratio;
  int               failures = 0, checks_done = 0, cyc = 0;
  ocpu_front #(.CYC(CYC)) fe (.mclk(mclk), .mag_rms(mag_rms), .mag_true_rms_value(mag_true_rms_value),
    .mag_pp(mag_pp), .blk_in(blk_in));
  ocpu_top #(.CYCLE_CLKS(CYC)) uut (.mclk(mclk), .rstn(rstn), .mag_rms(mag_rms),
    .mag_true_rms_value(mag_true_rms_value), .mag_pp(mag_pp), .meas_sel(meas_sel), .blk_in(blk_in),
    .inrush_en(inrush_en), .h2_ratio(h2_ratio), .h2_limit(h2_limit),
    .group_sel(group_sel), .iset_wr(iset_wr), .iset_wgrp(iset_wgrp),
    .iset_wdata(iset_wdata), .inv_mode(inv_mode), .dt_delay(dt_delay), .inv_k(inv_k),
    .ln_mode(ln_mode), .force_en(force_en), .force_cond(force_cond),
    .force_ph_start(force_ph_start), .force_ph_trip(force_ph_trip), .cond(cond),
    .ph_start(ph_start), .ph_trip(ph_trip), .start(start), .trip(trip),
    .blocked(blocked), .exp_time(exp_time), .rem_time(rem_time), .ratio(ratio),
    .ln_beh(ln_beh), .iset_rej(iset_rej));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and verdict
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      close_out();
    end
  end
  task close_out;
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  // Access tasks
  task wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt
  task ticks(input int n);
    wt(n * CYC);
  endtask : ticks
  task phs(input logic [15:0] a, b, c);
    fe.set_mag({c, b, a}, {c, b, a}, {c, b, a});
  endtask : phs
  task wr(input logic g, input logic [15:0] d);
    iset_wr = 1'b1;
    iset_wgrp = g;
    iset_wdata = d;
    wt(1);
    iset_wr = 1'b0;
    wt(2);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    wt(5);
    rstn = 1'b1;
    wt(1);
    `CHK("cond", 4'h1, cond)
    `CHK("rem_time", 20'h00000, rem_time)
    phs(16'h0064, 16'h0079, 16'h0064);
    ticks(3);
    `CHK("start", 1'b1, start)
    `CHK("ph_start", 3'h2, ph_start)
    `CHK("cond", 4'h2, cond)
    `CHK("ratio", 17'h00064, ratio)
    `CHK("exp_time", 19'h003e8, exp_time)
    `CHK("rem_time", 20'h003e6, rem_time)
    phs(16'h0064, 16'h0075, 16'h0064);
    ticks(3);
    `CHK("start", 1'b1, start)
    phs(16'h0064, 16'h0074, 16'h0064);
    ticks(3);
    `CHK("start", 1'b0, start)
    phs(16'h0078, 16'h0078, 16'h0078);
    ticks(3);
    `CHK("cond", 4'h1, cond)
    fe.set_blk(1'b1);
    phs(16'h00c8, 16'h00c8, 16'h00c8);
    ticks(3);
    `CHK("blocked", 1'b1, blocked)
    `CHK("start", 1'b0, start)
    `CHK("cond", 4'h8, cond)
    fe.set_blk(1'b0);
    ticks(3);
    `CHK("start", 1'b1, start)
    fe.set_blk(1'b1);
    ticks(3);
    `CHK("start", 1'b0, start)
    fe.set_blk(1'b0);
    inrush_en = 1'b1;
    h2_ratio = 16'h00c8;
    ticks(3);
    `CHK("blocked", 1'b1, blocked)
    inrush_en = 1'b0;
    ticks(3);
    `CHK("start", 1'b1, start)
    dt_delay = 19'h00003;
    ticks(6);
    `CHK("trip", 1'b1, trip)
    `CHK("cond", 4'h4, cond)
    `CHK("ph_trip", 3'h7, ph_trip)
    inv_mode = 1'b1;
    inv_k = 16'h000a;
    phs(16'h00f0, 16'h00f0, 16'h00f0);
    ticks(3);
    `CHK("exp_time", 19'h0000a, exp_time)
    phs(16'h0168, 16'h0168, 16'h0168);
    ticks(3);
    `CHK("exp_time", 19'h00005, exp_time)
    inv_mode = 1'b0;
    dt_delay = 19'h003e8;
    phs(16'h0064, 16'h0064, 16'h0064);
    wr(1'b0, 16'h0009);
    `CHK("iset_rej", 1'b1, iset_rej)
    wr(1'b0, 16'h1389);
    `CHK("iset_rej", 1'b1, iset_rej)
    wr(1'b0, 16'h1388);
    `CHK("iset_rej", 1'b0, iset_rej)
    wr(1'b0, 16'h0078);
    wr(1'b1, 16'h00c8);
    group_sel = 1'b1;
    phs(16'h0096, 16'h0096, 16'h0096);
    ticks(3);
    `CHK("start", 1'b0, start)
    group_sel = 1'b0;
    ticks(3);
    `CHK("start", 1'b1, start)
    `CHK("ratio", 17'h0007d, ratio)
    fe.set_mag({3{16'h0064}}, {3{16'h00c8}}, {3{16'h0064}});
    meas_sel = 2'h1;
    ticks(3);
    `CHK("start", 1'b1, start)
    meas_sel = 2'h2;
    ticks(3);
    `CHK("start", 1'b0, start)
    force_en = 1'b1;
    force_cond = 4'h4;
    force_ph_trip = 3'h5;
    wt(3);
    `CHK("cond", 4'h4, cond)
    `CHK("ph_trip", 3'h5, ph_trip)
    force_en = 1'b0;
    ticks(1);
    `CHK("cond", 4'h1, cond)
    for (int i = 0; i < 5; i++) begin
      ln_mode = i[2:0];
      wt(3);
      `CHK("ln_beh", ln_mode, ln_beh)
    end
    close_out();
  end
endmodule : tb
`default_nettype wire
